// File: inc/fuel_gauge_defines.svh
/*
 fuel gauge and standby control: offsets-free constants (clock, coefficients, thresholds, timing).
 assumes a 40 MHz reference clock; included by bare name.
*/
`ifndef FUEL_GAUGE_DEFINES_SVH
`define FUEL_GAUGE_DEFINES_SVH
`define CLK_HZ 40000000
`define CAP_COEF_NUM 1
`define CAP_COEF_DEN 5
`define LIGHT_LOAD_MA 50
`define STANDBY_TIME_S 30
`define STANDBY_CYCLES (`STANDBY_TIME_S * `CLK_HZ)
`define BLINK_SLOW_HZ 1
`define BLINK_FAST_HZ 2
`define SLOW_TOGGLE_CYCLES (`CLK_HZ / `BLINK_SLOW_HZ)
`define FAST_TOGGLE_CYCLES (`CLK_HZ / `BLINK_FAST_HZ)
`define LOW_PCT 5
`define FULL_PCT 100
`define CAL_EMPTY_PCT 0
`endif

// File: inc/fuel_gauge_pkg.sv
/*
 fuel gauge types.
 assumes nothing beyond the defines header.
*/
package fuel_gauge_pkg;
   typedef enum logic [1:0] {ST_STANDBY, ST_ACTIVE} power_state_e;
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} cal_state_e;
endpackage : fuel_gauge_pkg

// File: core/blink_gen.sv
/*
 blink generator: free running 0.5 Hz and 1 Hz square waves.
 assumes the 40 MHz reference clock.
*/
`timescale 1ns/1ps
`include "fuel_gauge_defines.svh"
module blink_gen #(
   parameter int SLOW_CYC = `SLOW_TOGGLE_CYCLES,
   parameter int FAST_CYC = `FAST_TOGGLE_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   output logic o_slow,
   output logic o_fast
);
   logic [31:0] slow_cnt;
   logic [31:0] fast_cnt;
   wire slow_wrap = (slow_cnt == 32'(SLOW_CYC - 1));
   wire fast_wrap = (fast_cnt == 32'(FAST_CYC - 1));
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         slow_cnt <= 32'h0;
         fast_cnt <= 32'h0;
         o_slow <= 1'b0;
         o_fast <= 1'b0;
      end else begin
         slow_cnt <= slow_wrap ? 32'h0 : slow_cnt + 32'h1;
         fast_cnt <= fast_wrap ? 32'h0 : fast_cnt + 32'h1;
         if (slow_wrap) o_slow <= ~o_slow;
         if (fast_wrap) o_fast <= ~o_fast;
      end
   end
endmodule : blink_gen

// File: core/fuel_gauge_standby_ctrl.sv
/*
 fuel gauge and standby control: capacity from resistor setting, coulomb counting,
 full-cycle recalibration, phone wake and light-load standby, percentage display.
 assumes current samples and the sample strobe come from logic on i_ref_clk;
 the phone-detect pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`include "fuel_gauge_defines.svh"
// Summary of operation
// R1: initial capacity in mAh is resistor setting in ohms times 0.2.
// R2: remaining charge accumulates signed battery current times elapsed sample time.
// R3: uninterrupted charge from empty to full replaces total capacity with charge gained.
// R4: phone attach leaves standby immediately and enables the 5 V boost.
// R5: standby after load below 50 mA for 30 s; timer restarts at or above threshold.
// R6: percentage display; 0.5 Hz blink charging, steady full, 1 Hz blink under 5 percent.
module fuel_gauge_standby_ctrl
   import fuel_gauge_pkg::*;
#(
   parameter int RSET_W = 20,
   parameter int CAP_W = 20,
   parameter int CUR_W = 16,
   parameter int ACC_W = 48,
   parameter int SAMPLES_PER_MAH = 3600,
   parameter longint STANDBY_CYC = `STANDBY_CYCLES,
   parameter int SLOW_CYC = `SLOW_TOGGLE_CYCLES,
   parameter int FAST_CYC = `FAST_TOGGLE_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [RSET_W-1:0] i_rset_ohm,
   input wire logic i_sample,
   input wire logic signed [CUR_W-1:0] i_bat_ma,
   input wire logic [CUR_W-1:0] i_load_ma,
   input wire logic i_charging,
   input wire logic i_charge_full,
   input wire logic i_phone_det,
   output logic o_boost_en,
   output logic o_standby,
   output logic [6:0] o_pct,
   output logic o_disp_on,
   output logic [CAP_W-1:0] o_full_cap_mah
);
   power_state_e pstate;
   cal_state_e cstate;
   logic det_m;
   logic det_s;
   logic det_d;
   logic init_done;
   logic signed [ACC_W-1:0] charge_acc;
   logic [ACC_W-1:0] cal_acc;
   logic [31:0] idle_cnt;
   logic blink_slow;
   logic blink_fast;

   function automatic logic [ACC_W-1:0] mah_to_units(input logic [CAP_W-1:0] mah);
      mah_to_units = ACC_W'(mah) * ACC_W'(SAMPLES_PER_MAH);
   endfunction : mah_to_units

   wire [CAP_W-1:0] rset_cap = CAP_W'((i_rset_ohm * `CAP_COEF_NUM) / `CAP_COEF_DEN); // R1
   wire [ACC_W-1:0] full_units = mah_to_units(o_full_cap_mah);
   wire signed [ACC_W-1:0] bat_ext = ACC_W'(i_bat_ma);
   wire signed [ACC_W-1:0] next_sum = charge_acc + bat_ext;
   wire signed [ACC_W-1:0] next_charge = next_sum < 0 ? '0 :
      (next_sum > $signed(full_units) ? $signed(full_units) : next_sum);
   wire [ACC_W+6:0] scaled = (ACC_W+7)'(charge_acc) * (ACC_W+7)'(100);
   wire [ACC_W+6:0] pct_raw = full_units == '0 ? '0 : scaled / (ACC_W+7)'(full_units);
   wire [6:0] next_pct = pct_raw > 100 ? 7'd100 : 7'(pct_raw);
   wire phone_rise = det_s & ~det_d;
   wire light_load = i_load_ma < CUR_W'(`LIGHT_LOAD_MA);
   wire idle_done = idle_cnt >= 32'(STANDBY_CYC - 1);
   wire is_full = i_charging & i_charge_full;
   wire low_batt = o_pct < 7'(`LOW_PCT);
   wire next_disp = is_full ? 1'b1 : (i_charging ? blink_slow : (low_batt ? blink_fast : 1'b1));
   wire empty_now = charge_acc == '0;

   blink_gen #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_blink (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .o_slow(blink_slow),
      .o_fast(blink_fast)
   );

   // phone-detect pin is asynchronous; det_m feeds only det_s
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         det_m <= 1'b0;
         det_s <= 1'b0;
         det_d <= 1'b0;
      end else begin
         det_m <= i_phone_det;
         det_s <= det_m;
         det_d <= det_s;
      end
   end

   // capacity loads once after reset release; the strap is caught by the clock, not the reset
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         init_done <= 1'b0;
         o_full_cap_mah <= '0;
         charge_acc <= '0;
         cal_acc <= '0;
         cstate <= CAL_IDLE;
      end else if (!init_done) begin
         init_done <= 1'b1;
         o_full_cap_mah <= rset_cap; // R1
      end else begin
         if (i_sample) charge_acc <= next_charge; // R2
         case (cstate)
            CAL_IDLE: begin
               if (i_charging && empty_now) begin
                  cstate <= CAL_RUN;
                  cal_acc <= '0;
               end
            end
            CAL_RUN: begin
               if (!i_charging) begin
                  cstate <= CAL_IDLE;
               end else if (i_charge_full) begin
                  cstate <= CAL_DONE;
                  o_full_cap_mah <= CAP_W'(cal_acc / ACC_W'(SAMPLES_PER_MAH)); // R3
                  charge_acc <= $signed(cal_acc);
               end else if (i_sample && i_bat_ma > 0) begin
                  cal_acc <= cal_acc + ACC_W'(bat_ext); // R3
               end
            end
            CAL_DONE: begin
               if (!i_charging) cstate <= CAL_IDLE;
            end
            default: cstate <= CAL_IDLE;
         endcase
      end
   end

   // light-load timer and power state; a fresh phone attach outranks the standby entry
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pstate <= ST_STANDBY;
         idle_cnt <= 32'h0;
         o_boost_en <= 1'b0;
         o_standby <= 1'b1;
      end else begin
         case (pstate)
            ST_STANDBY: begin
               idle_cnt <= 32'h0;
               if (phone_rise) begin
                  pstate <= ST_ACTIVE; // R4
                  o_boost_en <= 1'b1;
                  o_standby <= 1'b0;
               end
            end
            ST_ACTIVE: begin
               if (phone_rise || !light_load) begin
                  idle_cnt <= 32'h0; // R5
               end else if (idle_done) begin
                  pstate <= ST_STANDBY; // R5
                  o_boost_en <= 1'b0;
                  o_standby <= 1'b1;
                  idle_cnt <= 32'h0;
               end else begin
                  idle_cnt <= idle_cnt + 32'h1;
               end
            end
            default: pstate <= ST_STANDBY;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_pct <= 7'h0;
         o_disp_on <= 1'b0;
      end else begin
         o_pct <= is_full ? 7'd100 : next_pct; // R6
         o_disp_on <= next_disp; // R6
      end
   end

   a_wake_boost: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R4
      (phone_rise && pstate == ST_STANDBY) |=> o_boost_en && !o_standby)
      else $error("boost not enabled after phone attach");
   a_heavy_stays: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R5
      (pstate == ST_ACTIVE && !light_load) |=> !o_standby && idle_cnt == 32'h0)
      else $error("heavy load did not hold off standby");
   a_idle_sleep: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R5
      (pstate == ST_ACTIVE && light_load && !phone_rise && idle_done) |=> o_standby && !o_boost_en)
      else $error("standby not entered after light-load time");
   a_standby_pair: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R4
      o_standby == !o_boost_en)
      else $error("boost and standby disagree");
   a_cap_init: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R1
      !init_done |=> o_full_cap_mah == $past(rset_cap))
      else $error("initial capacity not taken from resistor");
   a_charge_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R2
      charge_acc >= 0 && charge_acc <= $signed(full_units) + $signed(ACC_W'(32767)))
      else $error("charge accumulator out of range");
   a_charge_step: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R2
      (init_done && i_sample && cstate != CAL_RUN) |=> charge_acc == $past(next_charge))
      else $error("charge not integrated");
   a_recal: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R3
      (init_done && cstate == CAL_RUN && i_charging && i_charge_full)
      |=> cstate == CAL_DONE && o_full_cap_mah == CAP_W'($past(cal_acc) / ACC_W'(SAMPLES_PER_MAH)))
      else $error("total capacity not recalibrated");
   a_full_steady: assert property (@(posedge i_ref_clk) disable iff (!i_rstn) // R6
      is_full |=> o_pct == 7'd100 && o_disp_on)
      else $error("full display not steady 100");
   c_wake: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) pstate == ST_STANDBY && phone_rise);
   c_sleep: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) pstate == ST_ACTIVE && idle_done);
   c_recal: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) cstate == CAL_RUN && i_charge_full);
   c_low: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) !i_charging && low_batt);
endmodule : fuel_gauge_standby_ctrl

// File: verif/batt_load_model.sv
/*
 far side of the gauge: battery current sensor with sample strobe, output load and phone-detect pin.
 assumes the bench moves its controls just after a falling edge of the reference clock.
*/
`timescale 1ns/1ps
module batt_load_model (
   input wire logic i_clk,
   input wire logic i_take,
   input wire logic signed [15:0] i_cur,
   input wire logic [15:0] i_load,
   input wire logic i_attach,
   output logic o_sample,
   output logic signed [15:0] o_bat_ma,
   output logic [15:0] o_load_ma,
   output logic o_phone_det
);
   logic signed [15:0] last = 16'sh0;
   always @(posedge i_clk) begin
      if (i_take) begin
         last <= i_cur;
      end
   end
   assign o_sample = i_take;
   // current means nothing between strobes, so show the inverse of the last strobed value rather than that value
   assign o_bat_ma = i_take ? i_cur : ~last;
   assign o_load_ma = i_load;
   assign o_phone_det = i_attach;
endmodule : batt_load_model

// File: verif/tb.sv
/*
 self-checking bench for the fuel gauge and standby control, with shortened counts.
 assumes the design and the battery/load model on one 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
   import fuel_gauge_pkg::*;
   localparam int SBY = 100;
   logic clk = 0, rstn = 0, take = 0, attach = 0, charging = 0, full = 0;
   logic signed [15:0] cur = 16'sh0;
   logic [15:0] load = 16'h0;
   logic [19:0] rset = 20'h0;
   logic smp, det, boost, sby, disp;
   logic signed [15:0] bat;
   logic [15:0] load_ma;
   logic [6:0] pct;
   logic [19:0] cap;
   int mismatches = 0, n_checks = 0, cycles = 0, sum, c;
   initial forever #12.5 clk = ~clk;
   batt_load_model model (.i_clk(clk), .i_take(take), .i_cur(cur), .i_load(load), .i_attach(attach),
      .o_sample(smp), .o_bat_ma(bat), .o_load_ma(load_ma), .o_phone_det(det));
   fuel_gauge_standby_ctrl #(.SAMPLES_PER_MAH(1), .STANDBY_CYC(SBY), .SLOW_CYC(8), .FAST_CYC(4)) dut (
      .i_ref_clk(clk), .i_rstn(rstn), .i_rset_ohm(rset), .i_sample(smp), .i_bat_ma(bat),
      .i_load_ma(load_ma), .i_charging(charging), .i_charge_full(full), .i_phone_det(det),
      .o_boost_en(boost), .o_standby(sby), .o_pct(pct), .o_disp_on(disp), .o_full_cap_mah(cap));
   function automatic int pct_of(input int acc, input int total);
      return acc * 100 / total;
   endfunction : pct_of
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic sample(input int ma);
      cur = 16'(ma);
      take = 1;
      cyc(1);
      take = 0;
      cyc(1);
   endtask : sample
   // counts display changes over n cycles; zero means steady
   task automatic chk_blink(input string nm, input bit exp, input int n);
      int t;
      logic prev;
      t = 0;
      prev = disp;
      repeat (n) begin
         cyc(1);
         if (disp !== prev) t++;
         prev = disp;
      end
      chk(nm, 32'(exp), 32'(t > 0));
   endtask : chk_blink
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'hb057));
      rset = 20'(500 + $urandom_range(500));
      cyc(6);
      chk("standby in reset", 1, sby);
      chk("boost in reset", 0, boost);
      cyc(6);
      rstn = 1;
      cyc(2);
      chk("capacity", rset / 5, cap);
      charging = 1;
      cyc(1);
      sum = 0;
      repeat (4) begin
         c = 6 + $urandom_range(14);
         sum += c;
         sample(c);
      end
      cyc(1);
      chk("pct charging", pct_of(sum, rset / 5), pct);
      chk_blink("slow blink", 1, 20);
      full = 1;
      cyc(3);
      chk("recal capacity", sum, cap);
      chk("pct full", 100, pct);
      chk("lit when full", 1, disp);
      chk_blink("steady when full", 0, 20);
      full = 0;
      charging = 0;
      cyc(1);
      // recalibrated total equals the charge held, so discharging starts at a steady 100
      chk("pct discharging", 100, pct);
      chk_blink("steady discharging", 0, 10);
      sample(1 - sum);
      cyc(1);
      chk("pct low", pct_of(1, sum), pct);
      chk_blink("fast blink", 1, 10);
      // an interrupted charge from empty must not recalibrate; the gain differs from the kept total
      sample(-1);
      charging = 1;
      cyc(1);
      c = sum + 1 + $urandom_range(20);
      sample(c);
      charging = 0;
      cyc(1);
      charging = 1;
      full = 1;
      cyc(3);
      chk("cap kept after cut charge", sum, cap);
      full = 0;
      charging = 0;
      cyc(1);
      $display("test gauge done");
      load = 16'd10;
      attach = 1;
      cyc(2);
      chk("boost before sync", 0, boost);
      cyc(1);
      chk("boost on wake", 1, boost);
      chk("standby on wake", 0, sby);
      $display("test wake done");
      cyc(50);
      // exactly at the threshold counts as a real load and restarts the idle timer
      load = 16'd50;
      cyc(1);
      load = 16'(49 - $urandom_range(49));
      cyc(SBY - 5);
      chk("active after restart", 1, boost);
      cyc(4);
      chk("active one cycle short", 1, boost);
      cyc(1);
      chk("standby after idle", 1, sby);
      chk("boost off after idle", 0, boost);
      $display("test idle done");
      wrap_up();
   end
endmodule : tb
